// >>> pcw_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PCW_REGS_SVH
`define PCW_REGS_SVH
// device-end registers
`define PCW_D_CFG1 12'h000
`define PCW_D_CFG3 12'h004
`define PCW_D_CFG4 12'h008
`define PCW_D_CTRL 12'h00C
`define PCW_D_BASE 12'h010
`define PCW_D_BASEH 12'h014
`define PCW_D_STAT 12'h018
// device field positions
`define PCW_WAKE_ACT_BIT 4
`define PCW_CARDBUS_BIT 2
`define PCW_WAKE_PTN_BIT 2
`define PCW_WAKE_PME_BIT 4
`define PCW_ENDIAN_BIT 0
`define PCW_ST_PME_BIT 0
// host-end registers
`define PCW_H_CTRL 12'h000
`define PCW_H_CMD 12'h004
`define PCW_H_ALO 12'h008
`define PCW_H_AHI 12'h00C
`define PCW_H_WLO 12'h010
`define PCW_H_WHI 12'h014
`define PCW_H_RLO 12'h018
`define PCW_H_RHI 12'h01C
`define PCW_H_STAT 12'h020
// host control bits
`define PCW_GO_BIT 0
`define PCW_WANT64_BIT 1
`define PCW_BRST_BIT 2
`define PCW_ISO_BIT 3
`define PCW_STRAP64_BIT 4
// reset values
`define PCW_CFG_RST 32'h0000_0000
`define PCW_HCTRL_RST 32'h0000_0004
// bus commands
`define PCW_CMD_IORD 4'h2
`define PCW_CMD_IOWR 4'h3
`define PCW_CMD_MEMRD 4'h6
`define PCW_CMD_MEMWR 4'h7
`define PCW_CMD_DAC 4'hD
// timing
`define PCW_CLK_NS 8
`define PCW_WAKE_PULSE_NS 40
`define PCW_WAKE_PULSE_CYC ((`PCW_WAKE_PULSE_NS + `PCW_CLK_NS - 1) / `PCW_CLK_NS)
`define PCW_DEVSEL_WAIT 5
`endif

// >>> pcw_pkg.sv
// state types of both bus ends
`default_nettype none
package pcw_pkg;
	typedef enum logic [1:0] {TGT_IDLE, TGT_DEC, TGT_DATA, TGT_TURN} pcw_tgt_st_t;
	typedef enum logic [1:0] {MST_IDLE, MST_ADDR, MST_DATA, MST_TURN} pcw_mst_st_t;
endpackage : pcw_pkg
`default_nettype wire

// >>> pcw_if.sv
// bus pins between host end and device end, with pull-up resolution
`default_nettype none
interface pcw_if (
	input wire logic clk
);
	logic [63:0] h_ad_o;
	logic h_ad_oe_lo;
	logic h_ad_oe_hi;
	logic [63:0] d_ad_o;
	logic d_ad_oe_lo;
	logic d_ad_oe_hi;
	logic [63:0] ad;
	logic [7:0] cbe_n;
	logic frame_n;
	logic irdy_n;
	logic req64_n;
	logic d_devsel_o;
	logic d_trdy_o;
	logic d_ack64_o;
	logic d_ctl_oe;
	logic devsel_n;
	logic trdy_n;
	logic ack64_n;
	logic d_pme_oe;
	logic power_event_n;
	logic bus_isolate_n;
	logic bus_rst_n;
	logic wake_pin;
	// undriven lines float high through the pull-ups
	assign ad[31:0] = d_ad_oe_lo ? d_ad_o[31:0] :
		(h_ad_oe_lo ? h_ad_o[31:0] : 32'hFFFF_FFFF);
	assign ad[63:32] = d_ad_oe_hi ? d_ad_o[63:32] :
		(h_ad_oe_hi ? h_ad_o[63:32] : 32'hFFFF_FFFF);
	assign devsel_n = d_ctl_oe ? d_devsel_o : 1'b1;
	assign trdy_n = d_ctl_oe ? d_trdy_o : 1'b1;
	assign ack64_n = d_ctl_oe ? d_ack64_o : 1'b1;
	assign power_event_n = d_pme_oe ? 1'b0 : 1'b1;
	modport dev (input ad, cbe_n, frame_n, irdy_n, req64_n, bus_isolate_n,
		bus_rst_n, output d_ad_o, d_ad_oe_lo, d_ad_oe_hi, d_devsel_o,
		d_trdy_o, d_ack64_o, d_ctl_oe, d_pme_oe, wake_pin);
	modport host (input ad, devsel_n, trdy_n, ack64_n, power_event_n,
		wake_pin, output h_ad_o, h_ad_oe_lo, h_ad_oe_hi, cbe_n, frame_n,
		irdy_n, req64_n, bus_isolate_n, bus_rst_n);
endinterface : pcw_if
`default_nettype wire

// >>> pcw_wake.sv
// shapes the motherboard wake / status-change pin
`default_nettype none
`include "pcw_regs.svh"
module pcw_wake #(
	parameter int PULSE_CYC = `PCW_WAKE_PULSE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// selection
	input wire logic card_bus_enable,
	input wire logic wake_active_sel,
	input wire logic wake_pattern_sel,
	// conditions
	input wire logic trigger,
	input wire logic status_level,
	// pin
	output logic pin
);
	localparam int CW = $clog2(PULSE_CYC + 1);
	if (PULSE_CYC < 1 || PULSE_CYC > 4096) begin : g_chk
		$error("pcw_wake: pulse width out of range");
	end
	logic trig_d;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic active;
	// a rising trigger starts a pulse of fixed width
	assign next_cnt = (trigger & ~trig_d) ? CW'(PULSE_CYC) :
		((cnt != '0) ? cnt - CW'(1) : '0);
	assign active = wake_active_sel ? (next_cnt != '0) : trigger; // RL20
	// card-bus mode ignores all wake selections
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trig_d <= 1'b0;
			cnt <= '0;
			pin <= 1'b0; // RL6
		end else begin
			trig_d <= trigger;
			cnt <= next_cnt;
			pin <= card_bus_enable ? status_level : // RL4 RL9
				(active ^ wake_pattern_sel); // RL5
		end
	end
endmodule : pcw_wake
`default_nettype wire

// >>> pcw_device.sv
// device end: power event, isolation, wake and 64-bit bus target
// How it works
// [RL1] power event pin: active-low open-drain request
// [RL2] isolated: release all bus outputs except power event
// [RL3] isolated: ignore bus inputs, reset and clock
// [RL4] shared pin is wake only without card-bus
// [RL5] four wake forms: high, low, pulses
// [RL6] after reset wake is active-high level
// [RL7] follows bit 0: wake with power event
// [RL8] follows bit 1: also needs isolation low
// [RL9] card-bus mode: wake selections have no effect
// [RL10] address phase: first clock of frame, low lanes
// [RL11] I/O byte address, memory dword address
// [RL12] data moves only when irdy and trdy low
// [RL13] big- and little-endian byte order supported
// [RL14] upper lanes: high address on DAC or req64
// [RL15] upper data lanes only after 64-bit negotiation
// [RL16] low enables: command, then data-phase byte enables
// [RL17] each byte enable governs its own lane
// [RL18] upper enables: command, or negotiated upper enables
// [RL19] req64 at bus reset release: 64-bit slot
// [RL20] active bit picks pulse, pattern bit polarity
//
// The register offsets and register access over APB were decided locally.
`default_nettype none
`include "pcw_regs.svh"
module pcw_device #(
	parameter int MEM_WORDS = 16,
	parameter int PULSE_CYC = `PCW_WAKE_PULSE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power management event from the network side
	input wire logic pm_event,
	// host bus
	pcw_if.dev bus
);
	localparam int IW = $clog2(MEM_WORDS);
	if (MEM_WORDS < 4 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_chk
		$error("pcw_device: MEM_WORDS must be a power of two >= 4");
	end

	// byte swap of one 32-bit word when big-endian order is selected
	function automatic logic [31:0] swap32(input logic [31:0] w,
		input logic big);
		swap32 = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction : swap32

	logic [31:0] cfg1, cfg3, cfg4, ctrl, base, base_hi;
	logic pme_status;
	logic slot64;
	logic [31:0] mem [MEM_WORDS];
	pcw_pkg::pcw_tgt_st_t st;
	logic frame_prev, rst_prev;
	logic [IW-1:0] idx;
	logic wr, w64;
	logic devsel_n, trdy_n, ack64_n, ctl_oe, ad_oe;
	logic [63:0] rd_q;

	// register decode
	wire isolated = ~bus.bus_isolate_n;
	wire big = ctrl[`PCW_ENDIAN_BIT];
	wire apb_setup = psel & ~penable;
	wire apb_wr = psel & penable & pready & pwrite;
	wire hit_cfg1 = paddr == `PCW_D_CFG1;
	wire hit_cfg3 = paddr == `PCW_D_CFG3;
	wire hit_cfg4 = paddr == `PCW_D_CFG4;
	wire hit_ctrl = paddr == `PCW_D_CTRL;
	wire hit_base = paddr == `PCW_D_BASE;
	wire hit_baseh = paddr == `PCW_D_BASEH;
	wire hit_stat = paddr == `PCW_D_STAT;
	wire mapped = hit_cfg1 | hit_cfg3 | hit_cfg4 | hit_ctrl | hit_base |
		hit_baseh | hit_stat;
	wire [31:0] stat_word = {29'h0, isolated, slot64, pme_status};
	wire [31:0] rd_mux = hit_cfg1 ? cfg1 : hit_cfg3 ? cfg3 :
		hit_cfg4 ? cfg4 : hit_ctrl ? ctrl : hit_base ? base :
		hit_baseh ? base_hi : hit_stat ? stat_word : 32'h0;

	// register bus answers in the cycle after setup
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			prdata <= apb_setup ? rd_mux : 32'h0;
			pslverr <= apb_setup & ~mapped;
		end
	end

	// register writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg1 <= `PCW_CFG_RST;
			cfg3 <= `PCW_CFG_RST;
			cfg4 <= `PCW_CFG_RST;
			ctrl <= `PCW_CFG_RST;
			base <= `PCW_CFG_RST;
			base_hi <= `PCW_CFG_RST;
		end else if (apb_wr) begin
			if (hit_cfg1) cfg1 <= pwdata;
			if (hit_cfg3) cfg3 <= pwdata;
			if (hit_cfg4) cfg4 <= pwdata;
			if (hit_ctrl) ctrl <= pwdata;
			if (hit_base) base <= pwdata;
			if (hit_baseh) base_hi <= pwdata;
		end
	end

	// power event: sticky, a new event wins over a clear
	wire pme_clr = apb_wr & hit_stat & pwdata[`PCW_ST_PME_BIT];
	wire next_pme = pm_event | (pme_status & ~pme_clr);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pme_status <= 1'b0;
		end else begin
			pme_status <= next_pme;
		end
	end

	// wake condition, optionally qualified by isolation
	wire wake_trig = next_pme & // RL7
		(~cfg4[`PCW_WAKE_PME_BIT] | isolated); // RL8
	pcw_wake #(
		.PULSE_CYC(PULSE_CYC)
	) u_wake (
		.clk(clk),
		.rst(rst),
		.card_bus_enable(cfg3[`PCW_CARDBUS_BIT]), // RL4
		.wake_active_sel(cfg1[`PCW_WAKE_ACT_BIT]),
		.wake_pattern_sel(cfg4[`PCW_WAKE_PTN_BIT]),
		.trigger(wake_trig),
		.status_level(next_pme),
		.pin(bus.wake_pin)
	);

	// address phase decode
	wire addr_phase = ~bus.frame_n & frame_prev & (st == pcw_pkg::TGT_IDLE); // RL10
	wire dac = bus.cbe_n[3:0] == `PCW_CMD_DAC;
	wire [3:0] cmd = dac ? bus.cbe_n[7:4] : bus.cbe_n[3:0]; // RL16 RL18
	wire [31:0] addr_hi = (dac | ~bus.req64_n) ? bus.ad[63:32] : 32'h0; // RL14
	wire is_io = (cmd == `PCW_CMD_IORD) | (cmd == `PCW_CMD_IOWR);
	wire is_mem = (cmd == `PCW_CMD_MEMRD) | (cmd == `PCW_CMD_MEMWR);
	wire is_rd = (cmd == `PCW_CMD_IORD) | (cmd == `PCW_CMD_MEMRD);
	// I/O keeps the byte offset out of the word index; memory
	// drops its low two bits, which only name the burst order
	wire win_hit = (bus.ad[31:IW+2] == base[31:IW+2]) & (addr_hi == base_hi); // RL11
	wire claim = addr_phase & win_hit & (is_io | is_mem);
	wire go64 = ~bus.req64_n & slot64 & is_mem;
	wire [IW-1:0] start_idx = {bus.ad[IW+1:3], bus.ad[2] & ~go64};

	// data phase and read data prefetch
	wire xfer = (st == pcw_pkg::TGT_DATA) & ~bus.irdy_n & ~trdy_n; // RL12
	wire last = xfer & bus.frame_n;
	wire [IW-1:0] next_idx = idx + (w64 ? IW'(2) : IW'(1));
	wire [IW-1:0] idx_p1 = idx + IW'(1);
	wire [IW-1:0] rd_base = (st == pcw_pkg::TGT_IDLE) ? start_idx : next_idx;
	wire [IW-1:0] rd_base1 = rd_base + IW'(1);
	wire [63:0] next_rd = {swap32(mem[rd_base1], big),
		swap32(mem[rd_base], big)}; // RL13

	// target state machine, frozen while isolated
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= pcw_pkg::TGT_IDLE;
			frame_prev <= 1'b1;
			rst_prev <= 1'b0;
			slot64 <= 1'b0;
			idx <= '0;
			wr <= 1'b0;
			w64 <= 1'b0;
			devsel_n <= 1'b1;
			trdy_n <= 1'b1;
			ack64_n <= 1'b1;
			ctl_oe <= 1'b0;
			ad_oe <= 1'b0;
			rd_q <= 64'h0;
		end else if (!isolated) begin // RL3
			frame_prev <= bus.frame_n;
			rst_prev <= bus.bus_rst_n;
			if (~rst_prev & bus.bus_rst_n) slot64 <= ~bus.req64_n; // RL19
			if (!bus.bus_rst_n) begin
				st <= pcw_pkg::TGT_IDLE;
				devsel_n <= 1'b1;
				trdy_n <= 1'b1;
				ack64_n <= 1'b1;
				ctl_oe <= 1'b0;
				ad_oe <= 1'b0;
			end else begin
				case (st)
				pcw_pkg::TGT_IDLE: if (claim) begin
					st <= pcw_pkg::TGT_DEC;
					idx <= start_idx;
					wr <= ~is_rd;
					w64 <= go64;
					devsel_n <= 1'b0;
					ack64_n <= ~go64; // RL15
					ctl_oe <= 1'b1;
					ad_oe <= is_rd;
					rd_q <= next_rd;
				end
				pcw_pkg::TGT_DEC: begin
					st <= pcw_pkg::TGT_DATA;
					trdy_n <= 1'b0;
				end
				pcw_pkg::TGT_DATA: if (xfer) begin
					idx <= next_idx;
					rd_q <= next_rd;
					if (last) begin
						st <= pcw_pkg::TGT_TURN;
						devsel_n <= 1'b1;
						trdy_n <= 1'b1;
						ack64_n <= 1'b1;
						ad_oe <= 1'b0;
					end
				end
				default: begin
					st <= pcw_pkg::TGT_IDLE;
					ctl_oe <= 1'b0;
				end
				endcase
			end
		end
	end

	// write data: each enabled low lane, and each enabled upper lane of a 64-bit transfer, lands in its byte of a word
	always_ff @(posedge clk) begin
		if (!isolated && bus.bus_rst_n && xfer && wr) begin
			for (int b = 0; b < 8; b++) begin
				if (!bus.cbe_n[b] && (b < 4 || w64)) begin // RL15 RL17
					mem[(b < 4) ? idx : idx_p1]
						[8 * (big ? 3 - (b % 4) : b % 4) +: 8] <=
						bus.ad[8 * b +: 8]; // RL13 RL16
				end
			end
		end
	end

	// pins; isolation releases the bus drivers at once, power event and wake pin stay driven
	assign bus.d_ad_o = rd_q;
	assign bus.d_ad_oe_lo = ad_oe & ~isolated; // RL2
	assign bus.d_ad_oe_hi = ad_oe & w64 & ~isolated; // RL2 RL15
	assign bus.d_devsel_o = devsel_n;
	assign bus.d_trdy_o = trdy_n;
	assign bus.d_ack64_o = ack64_n;
	assign bus.d_ctl_oe = ctl_oe & ~isolated; // RL2
	assign bus.d_pme_oe = pme_status; // RL1
endmodule : pcw_device
`default_nettype wire

// >>> pcw_host.sv
// host end: single-phase bus master, bus reset, isolation control
`default_nettype none
`include "pcw_regs.svh"
module pcw_host (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host bus
	pcw_if.host bus
);
	logic [31:0] ctrl, cmdr, alo, ahi, wlo, whi, rlo, rhi;
	logic busy, abort, got64, want;
	logic [3:0] cnt;
	pcw_pkg::pcw_mst_st_t st;

	// register decode
	wire apb_setup = psel & ~penable;
	wire apb_wr = psel & penable & pready & pwrite;
	wire hit_ctrl = paddr == `PCW_H_CTRL;
	wire hit_cmd = paddr == `PCW_H_CMD;
	wire hit_alo = paddr == `PCW_H_ALO;
	wire hit_ahi = paddr == `PCW_H_AHI;
	wire hit_wlo = paddr == `PCW_H_WLO;
	wire hit_whi = paddr == `PCW_H_WHI;
	wire hit_rlo = paddr == `PCW_H_RLO;
	wire hit_rhi = paddr == `PCW_H_RHI;
	wire hit_stat = paddr == `PCW_H_STAT;
	wire mapped = hit_ctrl | hit_cmd | hit_alo | hit_ahi | hit_wlo |
		hit_whi | hit_rlo | hit_rhi | hit_stat;
	wire [31:0] stat_word = {27'h0, bus.wake_pin, ~bus.power_event_n,
		got64, abort, busy};
	wire [31:0] rd_mux = hit_ctrl ? ctrl : hit_cmd ? cmdr : hit_alo ? alo :
		hit_ahi ? ahi : hit_wlo ? wlo : hit_whi ? whi : hit_rlo ? rlo :
		hit_rhi ? rhi : hit_stat ? stat_word : 32'h0;
	wire go = apb_wr & hit_ctrl & pwdata[`PCW_GO_BIT] & ~busy &
		~ctrl[`PCW_BRST_BIT];
	wire dac = ahi != 32'h0;
	wire is_wr = cmdr[0];

	// register bus answers in the cycle after setup
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			prdata <= apb_setup ? rd_mux : 32'h0;
			pslverr <= apb_setup & ~mapped;
		end
	end

	// register writes; go is not stored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= `PCW_HCTRL_RST;
			cmdr <= 32'h0;
			alo <= 32'h0;
			ahi <= 32'h0;
			wlo <= 32'h0;
			whi <= 32'h0;
		end else if (apb_wr) begin
			if (hit_ctrl) ctrl <= pwdata & ~(32'h1 << `PCW_GO_BIT);
			if (hit_cmd) cmdr <= pwdata;
			if (hit_alo) alo <= pwdata;
			if (hit_ahi) ahi <= pwdata;
			if (hit_wlo) wlo <= pwdata;
			if (hit_whi) whi <= pwdata;
		end
	end

	// master state machine: address phase, one data phase, turnaround
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= pcw_pkg::MST_IDLE;
			bus.frame_n <= 1'b1;
			bus.irdy_n <= 1'b1;
			bus.req64_n <= 1'b1;
			bus.cbe_n <= 8'hFF;
			bus.h_ad_o <= 64'h0;
			bus.h_ad_oe_lo <= 1'b0;
			bus.h_ad_oe_hi <= 1'b0;
			bus.bus_rst_n <= 1'b0;
			bus.bus_isolate_n <= 1'b1;
			rlo <= 32'h0;
			rhi <= 32'h0;
			busy <= 1'b0;
			abort <= 1'b0;
			got64 <= 1'b0;
			want <= 1'b0;
			cnt <= 4'h0;
		end else begin
			bus.bus_rst_n <= ~ctrl[`PCW_BRST_BIT];
			bus.bus_isolate_n <= ~ctrl[`PCW_ISO_BIT];
			case (st)
			pcw_pkg::MST_IDLE: begin
				// strap stays on through the edge that releases reset
				bus.req64_n <= ~(ctrl[`PCW_STRAP64_BIT] &
					(ctrl[`PCW_BRST_BIT] | ~bus.bus_rst_n)); // RL19
				if (go) begin
					st <= pcw_pkg::MST_ADDR;
					want <= pwdata[`PCW_WANT64_BIT];
					bus.frame_n <= 1'b0; // RL10
					bus.req64_n <= ~pwdata[`PCW_WANT64_BIT];
					bus.h_ad_o <= {ahi, alo}; // RL11 RL14
					bus.h_ad_oe_lo <= 1'b1;
					bus.h_ad_oe_hi <= dac | pwdata[`PCW_WANT64_BIT];
					bus.cbe_n <= dac ? {cmdr[3:0], `PCW_CMD_DAC} :
						{cmdr[3:0], cmdr[3:0]}; // RL16 RL18
					busy <= 1'b1;
					abort <= 1'b0;
					got64 <= 1'b0;
					cnt <= 4'h0;
				end
			end
			pcw_pkg::MST_ADDR: begin
				st <= pcw_pkg::MST_DATA;
				bus.frame_n <= 1'b1;
				bus.req64_n <= 1'b1;
				bus.irdy_n <= 1'b0;
				bus.cbe_n <= cmdr[11:4]; // RL16 RL17
				bus.h_ad_o <= {whi, wlo};
				bus.h_ad_oe_lo <= is_wr;
				bus.h_ad_oe_hi <= is_wr & want;
			end
			pcw_pkg::MST_DATA: begin
				cnt <= cnt + 4'h1;
				if (!bus.trdy_n) begin // RL12
					st <= pcw_pkg::MST_TURN;
					rlo <= bus.ad[31:0];
					if (!bus.ack64_n) begin // RL15
						rhi <= bus.ad[63:32];
						got64 <= 1'b1;
					end
					bus.irdy_n <= 1'b1;
					bus.h_ad_oe_lo <= 1'b0;
					bus.h_ad_oe_hi <= 1'b0;
				end else if (bus.devsel_n &&
					cnt == 4'(`PCW_DEVSEL_WAIT - 1)) begin
					st <= pcw_pkg::MST_TURN;
					abort <= 1'b1;
					bus.irdy_n <= 1'b1;
					bus.h_ad_oe_lo <= 1'b0;
					bus.h_ad_oe_hi <= 1'b0;
				end
			end
			default: begin
				st <= pcw_pkg::MST_IDLE;
				bus.cbe_n <= 8'hFF;
				busy <= 1'b0;
			end
			endcase
		end
	end
endmodule : pcw_host
`default_nettype wire

// >>> pcw_asserts.sv
// bus pin assertions between the host end and the device end
`default_nettype none
module pcw_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host side pins
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic req64_n,
	input wire logic [7:0] cbe_n,
	input wire logic bus_isolate_n,
	// device side pins
	input wire logic devsel_n,
	input wire logic trdy_n,
	input wire logic ack64_n,
	input wire logic d_ad_oe_lo,
	input wire logic d_ad_oe_hi,
	input wire logic d_ctl_oe,
	input wire logic power_event_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// isolation cuts the device off
	a_iso_all_off: assert property (
		!bus_isolate_n |-> !(d_ad_oe_lo || d_ad_oe_hi || d_ctl_oe))
		else $error("bus driven while isolated");
	a_iso_no_claim: assert property (
		$rose(bus_isolate_n) |-> devsel_n [*2])
		else $error("claim for a frame seen while isolated");
	// target handshake timing
	a_claim_after_addr: assert property (
		$fell(devsel_n) |-> $past(frame_n, 2) && !$past(frame_n))
		else $error("devsel not one cycle after address phase");
	a_ready_after_claim: assert property (
		$fell(trdy_n) |-> !devsel_n && $past(!devsel_n))
		else $error("trdy without a preceding devsel");
	a_ready_ends: assert property (
		!trdy_n && !irdy_n && frame_n |=> trdy_n)
		else $error("trdy held after the last data transfer");
	// 64-bit negotiation and lanes
	a_ack_with_claim: assert property (
		$fell(ack64_n) |-> $fell(devsel_n) && !$past(req64_n))
		else $error("ack64 without req64 or apart from devsel");
	a_hi_lanes_negot: assert property (
		d_ad_oe_hi |-> !ack64_n || $past(!ack64_n))
		else $error("upper lanes driven without 64-bit agreement");
	a_be_hold: assert property (
		!irdy_n && $past(!irdy_n) |-> $stable(cbe_n))
		else $error("byte enables changed within a data phase");
	// power event request
	a_event_holds: assert property (
		$fell(power_event_n) |=> !power_event_n)
		else $error("power event released at once");
endmodule : pcw_asserts
`default_nettype wire

// >>> pcw_bench.sv
// self-checking bench: host end and device end joined by the bus
`default_nettype none
`include "pcw_regs.svh"
module pcw_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PULSE = 2;
	localparam logic [31:0] BASE = 32'h0000_1000;
	localparam logic [31:0] W0 = 32'h1234_5678;
	localparam logic [31:0] W1 = 32'h9ABC_DEF0;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic d_psel = 1'h0;
	logic h_psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic pm_event = 1'h0;
	logic [31:0] d_prdata, h_prdata, v, lo, hi, st;
	logic d_pready, h_pready, d_pslverr, h_pslverr;
	int failures = 0;
	int check_count = 0;
	// clock and the two ends
	always #4 clk = ~clk;
	pcw_if bus (.clk(clk));
	pcw_device #(.PULSE_CYC(PULSE)) pcw_device_inst (.clk(clk), .rst(rst),
		.psel(d_psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(d_prdata), .pready(d_pready),
		.pslverr(d_pslverr), .pm_event(pm_event), .bus(bus.dev));
	pcw_host pcw_host_inst (.clk(clk), .rst(rst), .psel(h_psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(h_prdata), .pready(h_pready), .pslverr(h_pslverr),
		.bus(bus.host));
	pcw_asserts pcw_asserts_inst (.clk(clk), .rst(rst),
		.frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .req64_n(bus.req64_n),
		.cbe_n(bus.cbe_n), .bus_isolate_n(bus.bus_isolate_n),
		.devsel_n(bus.devsel_n), .trdy_n(bus.trdy_n), .ack64_n(bus.ack64_n),
		.d_ad_oe_lo(bus.d_ad_oe_lo), .d_ad_oe_hi(bus.d_ad_oe_hi),
		.d_ctl_oe(bus.d_ctl_oe), .power_event_n(bus.power_event_n));
	// verdict and comparison
	task automatic conclude();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	task automatic give_up();
		failures++;
		conclude();
	endtask : give_up
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one apb transfer to the device (dv=1) or the host (dv=0)
	task automatic apb(input logic dv, wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		d_psel <= dv;
		h_psel <= !dv;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		// pready, data and error are taken at the edge that ends the access
		do begin
			@(posedge clk);
			n++;
		end while ((dv ? d_pready : h_pready) !== 1'h1 && n < 20);
		if (n >= 20) begin
			give_up();
		end
		rd = dv ? d_prdata : h_prdata;
		err = dv ? d_pslverr : h_pslverr;
		d_psel <= 1'h0;
		h_psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wr(input logic dv, input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(dv, 1'h1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic dv, input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(dv, 1'h0, a, 32'h0, r, e);
	endtask : rd
	// one host bus transaction, waiting on the busy flag
	task automatic xfer(input logic [3:0] cmd, input logic [7:0] be_n,
		input logic [31:0] adr, wlo, whi, input logic w64, iso);
		int n;
		n = 0;
		wr(1'h0, `PCW_H_CMD, {20'h0, be_n, cmd});
		wr(1'h0, `PCW_H_ALO, adr);
		wr(1'h0, `PCW_H_AHI, 32'h0);
		wr(1'h0, `PCW_H_WLO, wlo);
		wr(1'h0, `PCW_H_WHI, whi);
		wr(1'h0, `PCW_H_CTRL, {28'h0, iso, 1'h0, w64, 1'h1});
		do begin
			rd(1'h0, `PCW_H_STAT, st);
			n++;
		end while (st[0] !== 1'h0 && n < 50);
		if (n >= 50) begin
			give_up();
		end
		rd(1'h0, `PCW_H_RLO, lo);
		rd(1'h0, `PCW_H_RHI, hi);
	endtask : xfer
	task automatic pulse_event();
		@(posedge clk);
		pm_event <= 1'h1;
		@(posedge clk);
		pm_event <= 1'h0;
		// return while a short wake pulse is still on the pin
		@(negedge clk);
	endtask : pulse_event
	// reset values, unmapped access, slot width
	task automatic t_regs();
		logic e;
		rd(1'h1, `PCW_D_CFG1, v);
		chk("cfg1", v, `PCW_CFG_RST);
		rd(1'h1, `PCW_D_CFG4, v);
		chk("cfg4", v, `PCW_CFG_RST);
		rd(1'h0, `PCW_H_CTRL, v);
		chk("host ctrl", v, `PCW_HCTRL_RST);
		apb(1'h1, 1'h0, 12'hFFC, 32'h0, v, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("wake idle", {31'h0, bus.wake_pin}, 32'h0);
		wr(1'h0, `PCW_H_CTRL, 32'h14);
		wr(1'h0, `PCW_H_CTRL, 32'h10);
		wr(1'h0, `PCW_H_CTRL, 32'h0);
		rd(1'h1, `PCW_D_STAT, v);
		chk("slot64", {31'h0, v[1]}, 32'h1);
		wr(1'h1, `PCW_D_BASE, BASE);
		wr(1'h1, `PCW_D_BASEH, 32'h0);
	endtask : t_regs
	// 64-bit, partial, byte-swapped, missed and isolated transfers
	task automatic t_mem();
		xfer(`PCW_CMD_MEMWR, 8'h00, BASE + 32'h8, W0, W1, 1'h1, 1'h0);
		xfer(`PCW_CMD_MEMRD, 8'h00, BASE + 32'h8, 32'h0, 32'h0, 1'h1, 1'h0);
		chk("read low", lo, W0);
		chk("read high", hi, W1);
		chk("got64", {31'h0, st[2]}, 32'h1);
		xfer(`PCW_CMD_MEMRD, 8'h00, BASE + 32'hC, 32'h0, 32'h0, 1'h0, 1'h0);
		chk("next dword", lo, W1);
		xfer(`PCW_CMD_MEMWR, 8'hFE, BASE + 32'h8, 32'h5555_5555, 32'h0,
			1'h0, 1'h0);
		xfer(`PCW_CMD_MEMRD, 8'h00, BASE + 32'h8, 32'h0, 32'h0, 1'h0, 1'h0);
		chk("byte lane 0", lo, {W0[31:8], 8'h55});
		wr(1'h1, `PCW_D_CTRL, 32'h1);
		xfer(`PCW_CMD_MEMRD, 8'h00, BASE + 32'hC, 32'h0, 32'h0, 1'h0, 1'h0);
		chk("swapped", lo, {W1[7:0], W1[15:8], W1[23:16], W1[31:24]});
		wr(1'h1, `PCW_D_CTRL, 32'h0);
		xfer(`PCW_CMD_MEMRD, 8'h00, 32'h9000_0000, 32'h0, 32'h0, 1'h0, 1'h0);
		chk("miss abort", {31'h0, st[1]}, 32'h1);
		// isolate first, so that no frame starts before the pin falls
		wr(1'h0, `PCW_H_CTRL, 32'h8);
		xfer(`PCW_CMD_MEMRD, 8'h00, BASE + 32'hC, 32'h0, 32'h0, 1'h0, 1'h1);
		chk("isolated abort", {31'h0, st[1]}, 32'h1);
		wr(1'h0, `PCW_H_CTRL, 32'h0);
		xfer(`PCW_CMD_MEMRD, 8'h00, BASE + 32'hC, 32'h0, 32'h0, 1'h0, 1'h0);
		chk("after isolation", lo, W1);
	endtask : t_mem
	// four wake forms, follow-isolation mode and card-bus pin
	task automatic t_wake();
		int n;
		int c;
		for (int f = 0; f < 4; f++) begin
			wr(1'h1, `PCW_D_CFG1, f[1] ? 32'h10 : 32'h0);
			wr(1'h1, `PCW_D_CFG4, f[0] ? 32'h4 : 32'h0);
			repeat (3) @(negedge clk);
			chk("wake idle", {31'h0, bus.wake_pin}, {31'h0, f[0]});
			pulse_event();
			chk("event pin", {31'h0, bus.power_event_n}, 32'h0);
			c = 0;
			repeat (16) begin
				if (bus.wake_pin !== f[0]) c++;
				@(negedge clk);
			end
			chk("wake cycles", 32'(c), f[1] ? PULSE : 16);
			wr(1'h1, `PCW_D_STAT, 32'h1);
			repeat (3) @(negedge clk);
			chk("event cleared", {31'h0, bus.power_event_n}, 32'h1);
		end
		wr(1'h1, `PCW_D_CFG1, 32'h0);
		wr(1'h1, `PCW_D_CFG4, 32'h10);
		pulse_event();
		chk("no wake unisolated", {31'h0, bus.wake_pin}, 32'h0);
		wr(1'h0, `PCW_H_CTRL, 32'h8);
		repeat (3) @(negedge clk);
		chk("wake isolated", {31'h0, bus.wake_pin}, 32'h1);
		chk("event kept", {31'h0, bus.power_event_n}, 32'h0);
		wr(1'h0, `PCW_H_CTRL, 32'h0);
		wr(1'h1, `PCW_D_STAT, 32'h1);
		wr(1'h1, `PCW_D_CFG3, 32'h4);
		wr(1'h1, `PCW_D_CFG4, 32'h14);
		repeat (3) @(negedge clk);
		chk("card idle", {31'h0, bus.wake_pin}, 32'h0);
		pulse_event();
		chk("card change", {31'h0, bus.wake_pin}, 32'h1);
	endtask : t_wake
	// main sequence and watchdog
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		t_regs();
		t_mem();
		t_wake();
		conclude();
	end
	initial begin
		repeat (60000) @(posedge clk);
		give_up();
	end
endmodule : pcw_bench
`default_nettype wire
